// ===== src/ildl_pkg.sv
// Constants, codes and carrier types of the interlock diagnostic logic.
// Assumes a single 50 MHz clock and an AXI4-Lite master for software access.
package ildl_pkg;

  // Clock rate and timing figures
  localparam longint unsigned CLK_HZ         = 64'd50000000;
  localparam longint unsigned WARN_TIME_MIN  = 64'd30;
  localparam longint unsigned WARN_CYCLES    = WARN_TIME_MIN * 64'd60 * CLK_HZ;
  localparam longint unsigned FLASH_PULSE_MS = 64'd250;
  localparam longint unsigned FLASH_GAP_MS   = 64'd1000;
  localparam longint unsigned BLINK_MS       = 64'd250;
  localparam longint unsigned FLASH_PULSE_CYCLES = FLASH_PULSE_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned FLASH_GAP_CYCLES   = FLASH_GAP_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned BLINK_CYCLES       = BLINK_MS * CLK_HZ / 64'd1000;

  // Daisy chain length limit
  localparam logic [4:0] CHAIN_MAX = 5'h1f;

  // Register byte offsets
  localparam logic [7:0] ADDR_REQ   = 8'h00;
  localparam logic [7:0] ADDR_RSP   = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;

  // Reset values and bus answers
  localparam logic [7:0] REQ_RESET   = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Red flash codes, pulses per burst
  localparam logic [3:0] CODE_NONE  = 4'h0;
  localparam logic [3:0] CODE_OUT_A = 4'h1;
  localparam logic [3:0] CODE_OUT_B = 4'h2;
  localparam logic [3:0] CODE_CROSS = 4'h3;
  localparam logic [3:0] CODE_ACT   = 4'h5;
  localparam logic [3:0] CODE_HOLD  = 4'h6;
  localparam logic [3:0] CODE_TEMP  = 4'ha;
  localparam logic [3:0] CODE_CONT  = 4'hf;

  // Request byte: bit0 magnet, bits 3:1 latching force, bit7 failure reset
  typedef struct packed {
    logic       reset;
    logic [2:0] spare;
    logic [2:0] latch_sel;
    logic       magnet;
  } ildl_req_s;

  // Response byte
  typedef struct packed {
    logic fail;
    logic warn;
    logic spare5;
    logic inputs_ok;
    logic spare3;
    logic locked;
    logic actuator;
    logic out_en;
  } ildl_rsp_s;

  // Yellow LED modes
  typedef enum logic [2:0] {
    YEL_OFF   = 3'b001,
    YEL_ON    = 3'b010,
    YEL_FLASH = 3'b100
  } ildl_yel_e;

endpackage : ildl_pkg

// ===== src/ildl_timer.sv
// Warning timer: counts while run is high, flags expiry, clears when run drops.
// Assumes run stays high for the whole delay; any gap restarts the count.
`timescale 1ns/1ps
`default_nettype none
module ildl_timer
  import ildl_pkg::*;
#(
  parameter int              CW    = 37,
  parameter longint unsigned LIMIT = WARN_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control and result
  input  wire logic run,
  output logic      expired
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } ildl_tmr_s;

  ildl_tmr_s q, d;

  // Count up to the limit, then hold the flag
  always_comb begin
    d = q;
    if (!run) begin
      d.cnt  = '0;
      d.done = 1'b0;
    end else if (q.cnt == CW'(LIMIT - 64'd1)) begin
      d.done = 1'b1;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.done;

endmodule : ildl_timer
`default_nettype wire

// ===== src/ildl_flash.sv
// Red LED flash-code generator: bursts of code pulses, then a long dark gap.
// Code 0 is dark and code 15 is steady, both at once; other code changes take effect at burst end.
`timescale 1ns/1ps
`default_nettype none
module ildl_flash
  import ildl_pkg::*;
#(
  parameter int              CW    = 26,
  parameter longint unsigned PULSE = FLASH_PULSE_CYCLES,
  parameter longint unsigned GAP   = FLASH_GAP_CYCLES
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Code in, LED out
  input  wire logic [3:0] code,
  output logic            led
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [3:0]    left;
    logic          on;
  } ildl_fl_s;

  ildl_fl_s q, d;

  // Pulse and gap sequencer
  always_comb begin
    d = q;
    if (code == CODE_NONE || code == CODE_CONT) begin
      d.cnt  = '0;
      d.left = 4'h0;
      d.on   = 1'b0;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - CW'(1);
    end else if (q.on) begin
      d.on   = 1'b0;
      d.left = q.left - 4'h1;
      d.cnt  = (q.left == 4'h1) ? CW'(GAP - 64'd1) : CW'(PULSE - 64'd1);
    end else begin
      d.on   = 1'b1;
      d.left = (q.left == 4'h0) ? code : q.left;
      d.cnt  = CW'(PULSE - 64'd1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q   <= '0;
      led <= 1'b0;
    end else begin
      q   <= d;
      led <= (code == CODE_CONT) | d.on;
    end
  end

endmodule : ildl_flash
`default_nettype wire

// ===== src/ildl_top.sv
// Interlock diagnostic logic: fault classes, outputs, LEDs, request and response bytes.
// Assumes sensor inputs are synchronous to aclk and an AXI4-Lite master on the bus.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Output A, output B, cross-wire faults flash 1, 2, 3 pulses; switch-off after 30 min.
// - Actuator, holding force, overtemperature flash 5, 6, 10; outputs drop at once.
// - Internal failure: red steady, both outputs off while it lasts.
// - Cross-wire and output A, B short faults give delayed switch-off; overtemperature drops at once.
// - Stored failure clears after guard open-close once cause gone; relock re-enables.
// - Warning keeps outputs on, runs 30 min timer, expiry becomes failure.
// - Warning clears by itself when its cause disappears.
// - Green on while supply present and device ready.
// - Yellow flashes when actuator is near edge of switching range.
// - Red active whenever failure or warning is present.
// - Diagnostic pin means guard closed, actuator in, locked if commanded; not safety.
// - Closed, commanded, locked: outputs high, yellow steady, diag high.
// - Closed, actuator in, command low: outputs low, yellow flashes, diag high.
// - Commanded but holding force short: outputs low, yellow flashes, diag low.
// - Requests pass along a chain of at most 31 devices.
// - Each device has one status byte and one request byte.
// - Gateway communication failure keeps the switching condition unchanged.
// - Request bit0 magnet, bits 3:1 force; response bits 0,1,2,4,6,7.
// - Falling reset bit of request byte also clears a failure once cause gone.
module ildl_top
  import ildl_pkg::*;
#(
  parameter int              ADDR_W     = 8,
  parameter longint unsigned WARN_CYC   = WARN_CYCLES,
  parameter longint unsigned PULSE_CYC  = FLASH_PULSE_CYCLES,
  parameter longint unsigned GAP_CYC    = FLASH_GAP_CYCLES,
  parameter longint unsigned BLINK_CYC  = BLINK_CYCLES
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Guard and lock sensing
  input  wire logic              guard_closed,
  input  wire logic              actuator_present,
  input  wire logic              actuator_near_edge,
  input  wire logic              lock_achieved,
  input  wire logic              solenoid_command,
  input  wire logic              upstream_enable_a,
  input  wire logic              upstream_enable_b,
  input  wire logic              supply_ok,
  // Fault detectors
  input  wire logic              fault_out_a,
  input  wire logic              fault_out_b,
  input  wire logic              fault_cross,
  input  wire logic              fault_actuator,
  input  wire logic              fault_holding,
  input  wire logic              fault_overtemp,
  input  wire logic              fault_internal,
  input  wire logic              comm_fail,
  // Serial diagnostic chain, upstream side
  input  wire logic              serial_diag_port_valid,
  input  wire logic [4:0]        serial_diag_port_addr,
  input  wire logic [7:0]        serial_diag_port_data,
  output logic                   sd_up_valid,
  output logic [7:0]             sd_up_data,
  // Serial diagnostic chain, downstream side
  output logic                   sd_dn_valid,
  output logic [4:0]             sd_dn_addr,
  output logic [7:0]             sd_dn_data,
  // Switching and indication
  output logic                   safety_switch_a,
  output logic                   safety_switch_b,
  output logic [2:0]             latch_force,
  output logic                   magnet_on,
  output logic                   led_green,
  output logic                   led_yellow,
  output logic                   led_red,
  output logic                   diag_signal_pin
);
  localparam int BW = $clog2(BLINK_CYC + 64'd1);

  typedef struct packed {
    ildl_req_s   req;
    logic        rst_prev;
    logic        fail;
    logic [3:0]  fail_code;
    logic        warn;
    logic        open_seen;
    logic [3:0]  code;
    logic        sw;
    logic        green;
    ildl_yel_e   yel;
    logic        blink;
    logic [BW-1:0] blink_cnt;
    logic        yellow;
    logic        diag;
    logic        magnet;
    logic        dn_valid;
    logic [4:0]  dn_addr;
    logic [7:0]  dn_data;
    logic        up_valid;
    logic [7:0]  up_data;
    logic        aw_got;
    logic        w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ildl_top_st_s;

  ildl_top_st_s q, d;
  logic         warn_expired;

  // Fault classes
  logic       imm_any;
  logic       dly_any;
  logic       cause_any;
  logic [3:0] imm_code;
  logic [3:0] dly_code;
  logic       cmd;
  logic       ready_ok;
  ildl_rsp_s  rsp;

  assign imm_any   = fault_actuator | fault_holding | fault_overtemp;
  assign dly_any   = fault_out_a | fault_out_b | fault_cross;
  assign cause_any = imm_any | dly_any | fault_internal;
  assign cmd       = solenoid_command | q.req.magnet;
  assign ready_ok  = supply_ok & ~fault_internal;

  // Highest pulse count is the most severe of each class
  assign imm_code = fault_overtemp ? CODE_TEMP :
                    fault_holding  ? CODE_HOLD :
                    fault_actuator ? CODE_ACT  : CODE_NONE;
  assign dly_code = fault_cross ? CODE_CROSS :
                    fault_out_b ? CODE_OUT_B :
                    fault_out_a ? CODE_OUT_A : CODE_NONE;

  // Response byte, refreshed every cycle
  always_comb begin
    rsp           = '0;
    rsp.out_en    = q.sw;
    rsp.actuator  = actuator_present;
    rsp.locked    = lock_achieved;
    rsp.inputs_ok = upstream_enable_a & upstream_enable_b;
    rsp.warn      = q.warn;
    rsp.fail      = q.fail | fault_internal;
  end

  // Warning delay runs only while a delayed fault is shown as a warning
  ildl_timer #(
    .CW    (37),
    .LIMIT (WARN_CYC)
  ) u_warn_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (q.warn),
    .expired (warn_expired)
  );

  // Red LED sequencer
  ildl_flash #(
    .CW    (26),
    .PULSE (PULSE_CYC),
    .GAP   (GAP_CYC)
  ) u_red_flash (
    .aclk    (aclk),
    .aresetn (aresetn),
    .code    (q.code),
    .led     (led_red)
  );

  // Next state of the whole block
  always_comb begin
    logic fail_set;
    logic fail_clr;
    logic rst_fall;
    logic sw_ok;
    fail_set = 1'b0;
    fail_clr = 1'b0;
    rst_fall = 1'b0;
    sw_ok    = 1'b0;
    d = q;

    // Request byte from the gateway; frozen while the link is down
    d.up_valid = 1'b0;
    d.dn_valid = 1'b0;
    if (!comm_fail && serial_diag_port_valid) begin
      if (serial_diag_port_addr == 5'h00) begin
        d.req      = ildl_req_s'(serial_diag_port_data);
        d.up_valid = 1'b1;
        d.up_data  = rsp;
      end else if (serial_diag_port_addr < CHAIN_MAX) begin
        d.dn_valid = 1'b1;
        d.dn_addr  = serial_diag_port_addr - 5'h01;
        d.dn_data  = serial_diag_port_data;
      end
    end

    // AXI4-Lite write: address and data in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got  = 1'b1;
      d.wdata  = s_axi_wdata[7:0];
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (d.aw_got && d.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_SLVERR;
      if (d.awaddr == ADDR_W'(ADDR_REQ)) begin
        d.bresp = RESP_OKAY;
        if (d.wstrb0 && !comm_fail) begin
          d.req = ildl_req_s'(d.wdata);
        end
      end else if (d.awaddr == ADDR_W'(ADDR_RSP) || d.awaddr == ADDR_W'(ADDR_FAULT)) begin
        d.bresp = RESP_OKAY;
      end
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;

    // AXI4-Lite read: answer one cycle after the address is taken
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h00000000;
      if (s_axi_araddr == ADDR_W'(ADDR_REQ)) begin
        d.rdata = {24'h000000, q.req};
      end else if (s_axi_araddr == ADDR_W'(ADDR_RSP)) begin
        d.rdata = {24'h000000, rsp};
      end else if (s_axi_araddr == ADDR_W'(ADDR_FAULT)) begin
        d.rdata = {24'h000000, q.fail_code, q.code};
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end
    d.arready = !d.rvalid;

    // Failure latch; a new fault in the clearing cycle wins
    rst_fall   = q.rst_prev & ~q.req.reset;
    d.rst_prev = q.req.reset;
    fail_set   = imm_any | (q.warn & warn_expired);
    if (q.fail && !guard_closed) begin
      d.open_seen = 1'b1;
    end
    fail_clr = !cause_any && ((q.open_seen && guard_closed) || rst_fall);
    if (fail_set) begin
      d.fail = 1'b1;
      if (!q.fail || imm_any) begin
        d.fail_code = imm_any ? imm_code : dly_code;
      end
    end else if (fail_clr) begin
      d.fail      = 1'b0;
      d.fail_code = CODE_NONE;
      d.open_seen = 1'b0;
    end

    // Warning follows its cause directly, no guard cycle needed
    d.warn = dly_any & ~d.fail;

    // Displayed code: internal, then immediate, then delayed
    if (fault_internal) begin
      d.code = CODE_CONT;
    end else if (d.fail) begin
      d.code = d.fail_code;
    end else if (d.warn) begin
      d.code = dly_code;
    end else begin
      d.code = CODE_NONE;
    end

    // Safety outputs: any immediate fault or latched failure drops them
    sw_ok = guard_closed & lock_achieved & cmd & upstream_enable_a & upstream_enable_b;
    d.sw  = sw_ok & ~imm_any & ~fault_internal & ~d.fail;

    // Green and diagnostic pin; diag is indication only
    d.green  = ready_ok;
    d.diag   = guard_closed & actuator_present & ~(cmd & ~lock_achieved)
             & ~d.fail & ~d.warn & ~fault_internal;
    d.magnet = cmd;

    // Yellow mode
    if (d.fail || fault_internal || !guard_closed) begin
      d.yel = YEL_OFF;
    end else if (actuator_near_edge || !d.sw) begin
      d.yel = actuator_present ? YEL_FLASH : YEL_OFF;
    end else begin
      d.yel = YEL_ON;
    end

    // Blink base shared by every flashing yellow mode
    if (q.blink_cnt == BW'(BLINK_CYC - 64'd1)) begin
      d.blink_cnt = '0;
      d.blink     = ~q.blink;
    end else begin
      d.blink_cnt = q.blink_cnt + BW'(1);
    end
    unique case (d.yel)
      YEL_OFF:   d.yellow = 1'b0;
      YEL_ON:    d.yellow = 1'b1;
      YEL_FLASH: d.yellow = d.blink;
      default:   d.yellow = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q     <= '0;
      q.req <= ildl_req_s'(REQ_RESET);
      q.yel <= YEL_OFF;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready   = q.awready;
  assign s_axi_wready    = q.wready;
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_arready   = q.arready;
  assign s_axi_rvalid    = q.rvalid;
  assign s_axi_rdata     = q.rdata;
  assign s_axi_rresp     = q.rresp;
  assign sd_up_valid     = q.up_valid;
  assign sd_up_data      = q.up_data;
  assign sd_dn_valid     = q.dn_valid;
  assign sd_dn_addr      = q.dn_addr;
  assign sd_dn_data      = q.dn_data;
  assign safety_switch_a = q.sw;
  assign safety_switch_b = q.sw;
  assign latch_force     = q.req.latch_sel;
  assign magnet_on       = q.magnet;
  assign led_green       = q.green;
  assign led_yellow      = q.yellow;
  assign diag_signal_pin = q.diag;

  // Falling reset bit, visible to the checks below
  logic rst_fall_w;
  assign rst_fall_w = q.rst_prev & ~q.req.reset;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_locked_ok;
    guard_closed && lock_achieved && solenoid_command && upstream_enable_a
      && upstream_enable_b && !cause_any && !q.fail && actuator_present
      && !actuator_near_edge;
  endsequence

  sequence s_cmd_low;
    guard_closed && actuator_present && !cmd && !cause_any && !q.fail;
  endsequence

  a_imm_fault_off: assert property (imm_any |=> !safety_switch_a && !safety_switch_b)
    else $error("outputs on after immediate fault");
  a_internal_red: assert property (fault_internal |=> q.code == CODE_CONT && !safety_switch_a)
    else $error("internal failure not shown steady");
  a_delay_warn: assert property (dly_any && !q.fail && !imm_any && !(q.warn && warn_expired)
    |=> q.warn)
    else $error("delayed fault not a warning");
  a_fail_sticky: assert property (q.fail && !q.open_seen && !rst_fall_w |=> q.fail)
    else $error("failure cleared without guard cycle");
  a_warn_expiry: assert property (q.warn && warn_expired && !imm_any |=> q.fail ##1 !safety_switch_a)
    else $error("warning expiry did not fail");
  a_warn_clear: assert property (q.warn && !dly_any |=> !q.warn)
    else $error("warning held without cause");
  a_green_ready: assert property (ready_ok |=> led_green)
    else $error("green off while ready");
  a_lock_state: assert property (s_locked_ok |=> safety_switch_a && q.yel == YEL_ON && diag_signal_pin)
    else $error("locked state outputs wrong");
  a_cmd_low: assert property (s_cmd_low |=> !safety_switch_a && q.yel == YEL_FLASH && diag_signal_pin)
    else $error("unlocked closed state wrong");
  a_weak_hold: assert property (cmd && guard_closed && !lock_achieved |=> !safety_switch_a && !diag_signal_pin)
    else $error("outputs on with weak hold");
  a_comm_hold: assert property (comm_fail |=> $stable(q.req))
    else $error("request changed during link failure");
  a_code_prio: assert property (fault_overtemp && fault_out_a && !fault_internal |=> q.code == CODE_TEMP)
    else $error("severity order wrong");

endmodule : ildl_top
`default_nettype wire

// ===== src/ildl_top_note_placeholder_removed.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== testbench/ildl_gw_model.sv
// Serial diagnostic gateway model at the head of the device chain.
// Assumes the device answers an addr-0 request one cycle after taking it.
`timescale 1ns/1ps
`default_nettype none
module ildl_gw_model (
  // Clock
  input  wire logic       aclk,
  // Request toward the chain head
  output logic            serial_diag_port_valid,
  output logic [4:0]      serial_diag_port_addr,
  output logic [7:0]      serial_diag_port_data,
  // Response from the chain head
  input  wire logic       sd_up_valid,
  input  wire logic [7:0] sd_up_data
);
  // Idle lines carry junk so a stale byte is never mistaken for a request
  initial begin
    serial_diag_port_valid = 1'b0;
    serial_diag_port_addr  = 5'h0a;
    serial_diag_port_data  = 8'h5a;
  end

  // One byte per device, addressed by chain position
  task automatic send(input logic [4:0] a, input logic [7:0] d,
                      output logic v, output logic [7:0] r);
    @(posedge aclk);
    {serial_diag_port_valid, serial_diag_port_addr, serial_diag_port_data} <= {1'b1, a, d};
    @(posedge aclk);
    {serial_diag_port_valid, serial_diag_port_addr, serial_diag_port_data} <= {1'b0, ~a, ~d};
    @(posedge aclk);
    {v, r} = {sd_up_valid, sd_up_data};
  endtask : send
endmodule : ildl_gw_model
`default_nettype wire

// ===== testbench/ildl_top_tb_top.sv
// Testbench of the interlock diagnostic logic: AXI4-Lite tasks and scenarios.
// Assumes shortened timer and flash counts; the gateway model drives the chain.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module ildl_top_tb_top;
  import ildl_pkg::*;
  localparam longint unsigned WARN = 64'd50;
  localparam logic [3:0] CODES [7] = '{CODE_OUT_A, CODE_OUT_B, CODE_CROSS, CODE_ACT,
                                       CODE_HOLD, CODE_TEMP, CODE_CONT};
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, guard_closed, actuator_present, actuator_near_edge, lock_achieved;
  logic solenoid_command, upstream_enable_a, upstream_enable_b, supply_ok, comm_fail;
  logic fault_out_a, fault_out_b, fault_cross, fault_actuator, fault_holding;
  logic fault_overtemp, fault_internal, serial_diag_port_valid, sd_up_valid, sd_dn_valid;
  logic safety_switch_a, safety_switch_b, magnet_on, led_green, led_yellow, led_red;
  logic diag_signal_pin, v;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, serial_diag_port_data, sd_up_data, sd_dn_data, sv, r;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  serial_diag_port_addr, sd_dn_addr;
  logic [6:0]  fv;
  logic [2:0]  latch_force;
  int          errors, samples_checked, cyc, nr, ny;

  // Sensor and fault levels packed so one assignment moves them all
  assign {guard_closed, actuator_present, actuator_near_edge, lock_achieved,
          solenoid_command, upstream_enable_a, upstream_enable_b, supply_ok} = sv;
  assign {fault_out_a, fault_out_b, fault_cross, fault_actuator, fault_holding,
          fault_overtemp, fault_internal} = fv;

  ildl_top #(.WARN_CYC(WARN), .PULSE_CYC(64'd4), .GAP_CYC(64'd16), .BLINK_CYC(64'd4))
    dut_u (.*);
  ildl_gw_model gw_u (.*);

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Hang guard, well above the length of all scenarios
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, 24'h0, d, 3'h7};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rdat, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd

  // Apply levels, then let the one-cycle pipeline settle
  task automatic set(input logic [7:0] s, input logic [6:0] f);
    @(posedge aclk);
    {sv, fv} <= {s, f};
    tick(3);
  endtask : set

  // Count cycles with red and yellow lit
  task automatic watch(input int k);
    {nr, ny} = '0;
    repeat (k) begin
      @(posedge aclk);
      nr += int'(led_red);
      ny += int'(led_yellow);
    end
  endtask : watch

  // Causes gone, then a falling reset bit clears any stored failure
  task automatic clr();
    set(8'hdf, 7'h00);
    wr(ADDR_REQ, 8'h80);
    wr(ADDR_REQ, 8'h00);
    tick(2);
  endtask : clr

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sv, fv, comm_fail} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    rd(ADDR_REQ);
    `CHK("req reset", 32'h0, rdat)
    rd(8'h0c);
    `CHK("unmapped resp", RESP_SLVERR, resp)
    wr(ADDR_REQ, 8'h0f);
    tick(1);
    `CHK("force and magnet", 4'hf, {latch_force, magnet_on})
    wr(ADDR_REQ, 8'h00);
    $display("test map finished");
    set(8'hdf, 7'h00);
    `CHK("locked outputs", 5'h1f, {safety_switch_a, safety_switch_b, diag_signal_pin, led_yellow, led_green})
    rd(ADDR_RSP);
    `CHK("rsp locked", 32'h17, rdat)
    gw_u.send(5'h00, 8'h00, v, r);
    `CHK("chain rsp", 9'h117, {v, r})
    gw_u.send(5'h05, 8'h3c, v, r);
    `CHK("forward", 14'h243c, {sd_dn_valid, sd_dn_addr, sd_dn_data})
    gw_u.send(5'h1f, 8'h00, v, r);
    `CHK("chain end", 2'h0, {v, sd_dn_valid})
    @(posedge aclk);
    comm_fail <= 1'b1;
    gw_u.send(5'h00, 8'h00, v, r);
    wr(ADDR_REQ, 8'h80);
    tick(3);
    `CHK("comm fail hold", 5'h0c, {v, safety_switch_a, safety_switch_b, resp})
    comm_fail <= 1'b0;
    $display("test locked finished");
    set(8'he7, 7'h00);
    watch(16);
    `CHK("cmd low", 4'h3, {safety_switch_a, safety_switch_b, diag_signal_pin, ny inside {[1:15]}})
    set(8'hcf, 7'h00);
    `CHK("weak hold", 3'h0, {safety_switch_a, safety_switch_b, diag_signal_pin})
    set(8'hdd, 7'h00);
    `CHK("one enable", 2'h0, {safety_switch_a, safety_switch_b})
    $display("test states finished");
    for (int i = 0; i < 7; i++) begin
      set(8'hdf, 7'h40 >> i);
      rd(ADDR_FAULT);
      `CHK("shown code", CODES[i], rdat[3:0])
      clr();
    end
    set(8'hdf, 7'h42);
    rd(ADDR_FAULT);
    `CHK("worst code", {CODE_TEMP, CODE_TEMP}, rdat[7:0])
    watch(40);
    `CHK("red and off", 3'h1, {safety_switch_a, safety_switch_b, nr > 0})
    set(8'hdf, 7'h00);
    `CHK("held off", 2'h0, {safety_switch_a, safety_switch_b})
    clr();
    `CHK("bit reset", 2'h3, {safety_switch_a, safety_switch_b})
    set(8'hdf, 7'h01);
    watch(8);
    `CHK("red steady", 3'h1, {safety_switch_a, safety_switch_b, nr == 8})
    clr();
    $display("test faults finished");
    set(8'hdf, 7'h10);
    rd(ADDR_RSP);
    `CHK("warn keeps on", 34'h3_0000_0057, {safety_switch_a, safety_switch_b, rdat})
    set(8'hdf, 7'h00);
    rd(ADDR_RSP);
    `CHK("warn gone", 32'h17, rdat)
    set(8'hdf, 7'h40);
    tick(int'(WARN));
    `CHK("warn expiry", 2'h0, {safety_switch_a, safety_switch_b})
    set(8'hdf, 7'h00);
    `CHK("stays off", 2'h0, {safety_switch_a, safety_switch_b})
    set(8'h5f, 7'h00);
    set(8'hdf, 7'h00);
    `CHK("reopen relock", 2'h3, {safety_switch_a, safety_switch_b})
    $display("test warning finished");
    end_of_test();
  end
endmodule : ildl_top_tb_top
`default_nettype wire
